/* File: pkg/cmrx_pkg.sv */
package cmrx_pkg;

  // register byte offsets (word index * 4)
  localparam logic [7:0] MASK0_STD_OFS = 8'h00;
  localparam logic [7:0] MASK0_EXT_OFS = 8'h04;
  localparam logic [7:0] MASK1_STD_OFS = 8'h08;
  localparam logic [7:0] MASK1_EXT_OFS = 8'h0C;
  localparam logic [7:0] MASK2_STD_OFS = 8'h10;
  localparam logic [7:0] MASK2_EXT_OFS = 8'h14;
  localparam logic [7:0] MASKSEL2_OFS  = 8'h18;
  localparam logic [7:0] RX_BUFFER_FULL_LO_OFS  = 8'h1C;
  localparam logic [7:0] RX_BUFFER_FULL_HI_OFS  = 8'h20;
  localparam logic [7:0] RX_BUFFER_OVERFLOW_LO_OFS  = 8'h24;
  localparam logic [7:0] RX_BUFFER_OVERFLOW_HI_OFS  = 8'h28;
  localparam logic [7:0] TRCON_OFS     = 8'h2C;

  // standard-word field positions and block counts
  localparam int STD_ID_LSB     = 5;
  localparam int MODE_BIT       = 3;
  localparam int EXT_HI_LSB     = 0;
  localparam int NUM_MASKS      = 3;
  localparam int NUM_BUFS       = 32;
  localparam int NUM_PAIRS      = 4;

  // per-buffer control byte positions
  localparam int DIR_BIT        = 7;
  localparam int ABT_BIT        = 6;
  localparam int LARB_BIT       = 5;
  localparam int ERR_BIT        = 4;
  localparam int REQ_BIT        = 3;
  localparam int RTR_BIT        = 2;
  localparam int PRI_LSB        = 0;

  localparam logic [15:0] STD_WRITE_MASK = 16'hFFEB;
  localparam logic [7:0]  CTL_WRITE_MASK = 8'h8F;
  localparam logic [15:0] ZERO16         = 16'h0000;
  localparam logic [1:0]  MSRC_RESERVED  = 2'h3;

  typedef struct packed {
    logic        valid;
    logic        ext;
    logic        remote;
    logic [28:0] id;
    logic [3:0]  filt_id;
    logic [28:0] filt_bits;
    logic        filt_ext;
    logic [1:0]  filt_msrc;
    logic [4:0]  buf_idx;
  } cmrx_rx_req_t;

  typedef struct packed {
    logic       done;
    logic       aborted;
    logic       arb_lost;
    logic       bus_err;
    logic [2:0] pair_buf;
  } cmrx_tx_evt_t;

  typedef struct packed {
    logic        valid;
    logic [4:0]  buf_idx;
    logic [4:0]  filter_code;
  } cmrx_store_t;

endpackage

/* File: design/cmrx_mask_match.sv */
`timescale 1ns/1ps
`default_nettype none
// combinational acceptance compare of one frame against one filter + mask
module cmrx_mask_match (
  // frame and filter
  input  wire logic [28:0] id_i,
  input  wire logic        ext_i,
  input  wire logic [28:0] filt_bits_i,
  input  wire logic        filt_ext_i,
  // selected mask
  input  wire logic [28:0] mask_i,
  input  wire logic        mode_i,
  // result
  output logic             hit_o
);
  logic bits_eq;
  always_comb begin
    bits_eq = ((id_i ^ filt_bits_i) & mask_i) == 29'h0000000; // R3 R4
    if (mode_i) begin
      hit_o = bits_eq && (ext_i == filt_ext_i); // R5
    end else begin
      hit_o = bits_eq; // R4
    end
  end
endmodule
`default_nettype wire

/* File: design/cmrx_core.sv */
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// R1 - three masks, each a standard and extended word
// R2 - std id 15-5, ext 17:16 at 1-0
// R3 - mask one compares bit, zero ignores it
// R4 - mode zero ignores frame identifier type
// R5 - mode one requires matching identifier type
// R6 - filter 8 mask source in bits 1-0
// R7 - code 00/01/10 selects mask, 11 reserved
// R8 - 32 full flags in two registers
// R9 - full flag set on store, resets zero
// R10 - software writes zero to clear full
// R11 - overflow set when storing into full buffer
// R12 - overflow cleared by zero write only
// R13 - control upper byte buffer n, lower m
// R14 - send request queues, clears on success
// R15 - clearing pending request asks for abort
// R16 - read-only aborted, lost, error flags
// R17 - status flags cleared when request set
// R18 - remote reply enable auto-transmits buffer
// R19 - two-bit priority orders pending sends
// R20 - message contents live in system memory
// R21 - store writes accepting filter code
module cmrx_core (
  // clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 ce_i,
  // classic wishbone slave
  input  wire logic                 cyc_i,
  input  wire logic                 stb_i,
  input  wire logic                 we_i,
  input  wire logic [7:0]           adr_i,
  input  wire logic [3:0]           sel_i,
  input  wire logic [31:0]          dat_i,
  output logic [31:0]               dat_o,
  output logic                      ack_o,
  // receive side from protocol engine
  input  wire cmrx_pkg::cmrx_rx_req_t rx_req_i,
  // transmit results from protocol engine
  input  wire cmrx_pkg::cmrx_tx_evt_t tx_evt_i,
  // store command to message memory
  output cmrx_pkg::cmrx_store_t     store_o,
  // transmit arbitration
  output logic                      tx_valid_o,
  output logic [2:0]                tx_buf_o,
  output logic                      tx_abort_o,
  output logic [2:0]                tx_abort_buf_o
);

  typedef struct packed {
    logic [2:0][15:0]  mstd;
    logic [2:0][15:0]  mext;
    logic [1:0]        f8_msrc;
    logic [31:0]       full;
    logic [31:0]       ovf;
    logic [7:0][7:0]   ctl;
    logic [31:0]       rdat;
    logic              ack;
    cmrx_pkg::cmrx_store_t store;
    logic              tx_valid;
    logic [2:0]        tx_buf;
    logic              tx_abort;
    logic [2:0]        tx_abort_buf;
  } cmrx_state_t;

  cmrx_state_t s_q;
  cmrx_state_t s_d;

  // buffers 0..7 are the transmit-capable pair buffers, in byte order of the control words
  function automatic logic [28:0] mask_bits(input logic [15:0] sw, input logic [15:0] ew);
    mask_bits = {sw[15:cmrx_pkg::STD_ID_LSB], sw[1:cmrx_pkg::EXT_HI_LSB], ew}; // R2
  endfunction

  logic [28:0] sel_mask;
  logic        sel_mode;
  logic [1:0]  msrc;
  logic        hit;
  logic        req_access;
  logic        wr_stb;
  logic [15:0] wdat;

  always_comb begin
    msrc = (rx_req_i.filt_id == 4'h8) ? s_q.f8_msrc : rx_req_i.filt_msrc; // R6
    sel_mask = 29'h0000000;
    sel_mode = 1'b0;
    unique case (msrc) // R7
      2'h0: begin
        sel_mask = mask_bits(s_q.mstd[0], s_q.mext[0]);
        sel_mode = s_q.mstd[0][cmrx_pkg::MODE_BIT];
      end
      2'h1: begin
        sel_mask = mask_bits(s_q.mstd[1], s_q.mext[1]);
        sel_mode = s_q.mstd[1][cmrx_pkg::MODE_BIT];
      end
      2'h2: begin
        sel_mask = mask_bits(s_q.mstd[2], s_q.mext[2]);
        sel_mode = s_q.mstd[2][cmrx_pkg::MODE_BIT];
      end
      2'h3: begin
        sel_mask = 29'h1FFFFFFF;
        sel_mode = 1'b1;
      end
    endcase
  end

  cmrx_mask_match u_match (
    .id_i        (rx_req_i.id),
    .ext_i       (rx_req_i.ext),
    .filt_bits_i (rx_req_i.filt_bits),
    .filt_ext_i  (rx_req_i.filt_ext),
    .mask_i      (sel_mask),
    .mode_i      (sel_mode),
    .hit_o       (hit)
  );

  always_comb begin
    req_access = cyc_i && stb_i && !s_q.ack;
    wr_stb     = req_access && we_i;
    wdat       = {sel_i[1] ? dat_i[15:8] : 8'h00, sel_i[0] ? dat_i[7:0] : 8'h00};
  end

  // byte-lane aware 16-bit write merge
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] nw,
                                          input logic [3:0] sel);
    merge16 = {sel[1] ? nw[15:8] : old[15:8], sel[0] ? nw[7:0] : old[7:0]};
  endfunction

  logic [4:0]  hp_idx;
  logic        hp_found;
  logic [1:0]  hp_pri;
  logic        rx_ok;
  logic        rx_reserved;

  always_comb begin
    logic [7:0]  b;
    logic        was_req;
    logic [2:0]  tb;
    b = 8'h00;
    was_req = 1'b0;
    tb = 3'h0;
    s_d = s_q;
    s_d.ack = req_access;
    s_d.store.valid = 1'b0;
    s_d.tx_abort = 1'b0;
    rx_reserved = (msrc == cmrx_pkg::MSRC_RESERVED);
    rx_ok = rx_req_i.valid && hit && !rx_reserved;

    // register reads
    s_d.rdat = 32'h00000000;
    if (req_access && !we_i) begin
      unique case (adr_i)
        cmrx_pkg::MASK0_STD_OFS: s_d.rdat[15:0] = s_q.mstd[0] & cmrx_pkg::STD_WRITE_MASK; // R1
        cmrx_pkg::MASK0_EXT_OFS: s_d.rdat[15:0] = s_q.mext[0];
        cmrx_pkg::MASK1_STD_OFS: s_d.rdat[15:0] = s_q.mstd[1] & cmrx_pkg::STD_WRITE_MASK;
        cmrx_pkg::MASK1_EXT_OFS: s_d.rdat[15:0] = s_q.mext[1];
        cmrx_pkg::MASK2_STD_OFS: s_d.rdat[15:0] = s_q.mstd[2] & cmrx_pkg::STD_WRITE_MASK;
        cmrx_pkg::MASK2_EXT_OFS: s_d.rdat[15:0] = s_q.mext[2];
        cmrx_pkg::MASKSEL2_OFS:  s_d.rdat[1:0]  = s_q.f8_msrc;
        cmrx_pkg::RX_BUFFER_FULL_LO_OFS:  s_d.rdat[15:0] = s_q.full[15:0]; // R8
        cmrx_pkg::RX_BUFFER_FULL_HI_OFS:  s_d.rdat[15:0] = s_q.full[31:16];
        cmrx_pkg::RX_BUFFER_OVERFLOW_LO_OFS:  s_d.rdat[15:0] = s_q.ovf[15:0];
        cmrx_pkg::RX_BUFFER_OVERFLOW_HI_OFS:  s_d.rdat[15:0] = s_q.ovf[31:16];
        cmrx_pkg::TRCON_OFS:     s_d.rdat       = s_q.ctl[3:0]; // R16
        cmrx_pkg::TRCON_OFS + 8'h04: s_d.rdat   = s_q.ctl[7:4];
        default:                 s_d.rdat       = 32'h00000000;
      endcase
    end

    // register writes
    if (wr_stb) begin
      unique case (adr_i)
        cmrx_pkg::MASK0_STD_OFS: s_d.mstd[0] = merge16(s_q.mstd[0], wdat, sel_i);
        cmrx_pkg::MASK0_EXT_OFS: s_d.mext[0] = merge16(s_q.mext[0], wdat, sel_i);
        cmrx_pkg::MASK1_STD_OFS: s_d.mstd[1] = merge16(s_q.mstd[1], wdat, sel_i);
        cmrx_pkg::MASK1_EXT_OFS: s_d.mext[1] = merge16(s_q.mext[1], wdat, sel_i);
        cmrx_pkg::MASK2_STD_OFS: s_d.mstd[2] = merge16(s_q.mstd[2], wdat, sel_i);
        cmrx_pkg::MASK2_EXT_OFS: s_d.mext[2] = merge16(s_q.mext[2], wdat, sel_i);
        cmrx_pkg::MASKSEL2_OFS: begin
          if (sel_i[0]) begin
            s_d.f8_msrc = dat_i[1:0]; // R6
          end
        end
        // zero written in an enabled lane clears; ones leave flags alone
        cmrx_pkg::RX_BUFFER_FULL_LO_OFS: s_d.full[15:0]  = s_q.full[15:0]  & ~merge16(ZEROCLR(), ~wdat, sel_i); // R10
        cmrx_pkg::RX_BUFFER_FULL_HI_OFS: s_d.full[31:16] = s_q.full[31:16] & ~merge16(ZEROCLR(), ~wdat, sel_i);
        cmrx_pkg::RX_BUFFER_OVERFLOW_LO_OFS: s_d.ovf[15:0]   = s_q.ovf[15:0]   & ~merge16(ZEROCLR(), ~wdat, sel_i); // R12
        cmrx_pkg::RX_BUFFER_OVERFLOW_HI_OFS: s_d.ovf[31:16]  = s_q.ovf[31:16]  & ~merge16(ZEROCLR(), ~wdat, sel_i);
        default: begin
        end
      endcase
      if (adr_i == cmrx_pkg::TRCON_OFS || adr_i == cmrx_pkg::TRCON_OFS + 8'h04) begin
        for (int w = 0; w < 4; w++) begin
          if (sel_i[w]) begin
            // the low control word carries buffers 0..3, the high word 4..7
            tb = {adr_i != cmrx_pkg::TRCON_OFS, w[1:0]}; // R13
            b = dat_i[8*w +: 8];
            was_req = s_q.ctl[tb][cmrx_pkg::REQ_BIT];
            // status bits are read-only; only direction, request, reply enable, priority take writes
            s_d.ctl[tb] = (s_q.ctl[tb] & ~cmrx_pkg::CTL_WRITE_MASK) | (b & cmrx_pkg::CTL_WRITE_MASK); // R13 R19
            if (b[cmrx_pkg::REQ_BIT] && !was_req) begin
              s_d.ctl[tb][cmrx_pkg::ABT_BIT]  = 1'b0; // R17
              s_d.ctl[tb][cmrx_pkg::LARB_BIT] = 1'b0;
              s_d.ctl[tb][cmrx_pkg::ERR_BIT]  = 1'b0;
            end
            if (!b[cmrx_pkg::REQ_BIT] && was_req) begin
              // keep the request until the engine confirms the abort
              s_d.ctl[tb][cmrx_pkg::REQ_BIT] = 1'b1; // R15
              s_d.tx_abort     = 1'b1;
              s_d.tx_abort_buf = tb;
            end
          end
        end
      end
    end

    // receive store: hardware set beats software clear in the same cycle
    if (rx_ok) begin
      s_d.store.valid       = 1'b1; // R20
      s_d.store.buf_idx     = rx_req_i.buf_idx;
      s_d.store.filter_code = {1'b0, rx_req_i.filt_id}; // R21
      if (s_q.full[rx_req_i.buf_idx]) begin
        s_d.ovf[rx_req_i.buf_idx] = 1'b1; // R11
      end
      s_d.full[rx_req_i.buf_idx] = 1'b1; // R9
      if (rx_req_i.remote && rx_req_i.buf_idx < 5'd8) begin
        tb = rx_req_i.buf_idx[2:0];
        if (s_q.ctl[tb][cmrx_pkg::DIR_BIT] && s_q.ctl[tb][cmrx_pkg::RTR_BIT]) begin
          s_d.ctl[tb][cmrx_pkg::REQ_BIT] = 1'b1; // R18
          s_d.ctl[tb][cmrx_pkg::ABT_BIT] = 1'b0;
          s_d.ctl[tb][cmrx_pkg::LARB_BIT] = 1'b0;
          s_d.ctl[tb][cmrx_pkg::ERR_BIT] = 1'b0;
        end
      end
    end

    // transmit results from the engine
    tb = tx_evt_i.pair_buf;
    if (tx_evt_i.done) begin
      s_d.ctl[tb][cmrx_pkg::REQ_BIT] = 1'b0; // R14
    end
    if (tx_evt_i.aborted) begin
      s_d.ctl[tb][cmrx_pkg::REQ_BIT] = 1'b0;
      s_d.ctl[tb][cmrx_pkg::ABT_BIT] = 1'b1; // R16
    end
    if (tx_evt_i.arb_lost) begin
      s_d.ctl[tb][cmrx_pkg::LARB_BIT] = 1'b1;
    end
    if (tx_evt_i.bus_err) begin
      s_d.ctl[tb][cmrx_pkg::ERR_BIT] = 1'b1;
    end

    // pick highest priority pending transmit; lower index wins a tie
    hp_found = 1'b0;
    hp_idx   = 5'h00;
    hp_pri   = 2'h0;
    for (int i = 0; i < 8; i++) begin
      if (s_q.ctl[i][cmrx_pkg::DIR_BIT] && s_q.ctl[i][cmrx_pkg::REQ_BIT] &&
          (!hp_found || s_q.ctl[i][1:0] > hp_pri)) begin
        hp_found = 1'b1;
        hp_idx   = 5'(i);
        hp_pri   = s_q.ctl[i][1:0]; // R19
      end
    end
    s_d.tx_valid = hp_found;
    s_d.tx_buf   = hp_idx[2:0];
  end

  function automatic logic [15:0] ZEROCLR();
    ZEROCLR = cmrx_pkg::ZERO16;
  endfunction

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else if (ce_i) begin
      s_q <= s_d;
    end
  end

  assign dat_o          = s_q.rdat;
  assign ack_o          = s_q.ack;
  assign store_o        = s_q.store;
  assign tx_valid_o     = s_q.tx_valid;
  assign tx_buf_o       = s_q.tx_buf;
  assign tx_abort_o     = s_q.tx_abort;
  assign tx_abort_buf_o = s_q.tx_abort_buf;

endmodule
`default_nettype wire

/* File: verification/cmrx_core_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module cmrx_core_chk (
  // clock and bus
  input wire logic                   clk_i,
  input wire logic                   rst_i,
  input wire logic                   ce_i,
  input wire logic                   cyc_i,
  input wire logic                   stb_i,
  input wire logic                   we_i,
  input wire logic [7:0]             adr_i,
  input wire logic [31:0]            dat_o,
  input wire logic                   ack_o,
  // receive and transmit
  input wire cmrx_pkg::cmrx_rx_req_t rx_req_i,
  input wire cmrx_pkg::cmrx_store_t  store_o,
  input wire logic                   tx_valid_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_take;
    cyc_i && stb_i && !ack_o && ce_i;
  endsequence
  sequence s_rx;
    rx_req_i.valid && ce_i;
  endsequence
  a_ack_after_take: assert property (s_take |=> ack_o)
    else $error("ack missing after request");
  a_ack_one_pulse: assert property (ack_o && ce_i |=> !ack_o)
    else $error("ack held too long");
  a_reset_quiet: assert property ($fell(rst_i) |-> !ack_o && !store_o.valid && !tx_valid_o)
    else $error("outputs active after reset");
  a_unmapped_zero: assert property (s_take ##0 (!we_i && adr_i > 8'h33) |=> dat_o == 32'h0)
    else $error("unmapped read not zero");
  a_mask_gap_bits: assert property (s_take ##0 (!we_i && adr_i inside {8'h00, 8'h08, 8'h10})
    |=> dat_o[4] == 1'b0 && dat_o[2] == 1'b0)
    else $error("mask gap bits read nonzero");
  a_store_has_cause: assert property (store_o.valid |-> $past(rx_req_i.valid))
    else $error("store without candidate");
  a_store_buffer: assert property (s_rx ##1 store_o.valid |-> store_o.buf_idx == $past(rx_req_i.buf_idx))
    else $error("store buffer index wrong");
  a_filter_code: assert property (store_o.valid |-> store_o.filter_code == {1'b0, $past(rx_req_i.filt_id)})
    else $error("filter code wrong");
  // filter 8 takes its mask code from its own register, not from the request
  a_reserved_reject: assert property (s_rx ##0 (rx_req_i.filt_msrc == 2'h3 &&
    rx_req_i.filt_id != 4'h8) |=> !store_o.valid)
    else $error("reserved mask code accepted");
endmodule
bind cmrx_core cmrx_core_chk i_cmrx_core_chk (
  .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
  .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o), .rx_req_i(rx_req_i), .store_o(store_o),
  .tx_valid_o(tx_valid_o)
);
`default_nettype wire

/* File: verification/cmrx_engine_model.sv */
`timescale 1ns/1ps
`default_nettype none
// protocol engine stand-in: sends the offered buffer after DELAY+1 cycles unless held
module cmrx_engine_model #(
  parameter int DELAY = 4
) (
  // clock and control
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             hold_i,
  // requests from the block
  input  wire logic             tx_valid_i,
  input  wire logic [2:0]       tx_buf_i,
  input  wire logic             tx_abort_i,
  input  wire logic [2:0]       tx_abort_buf_i,
  // results back to the block
  output cmrx_pkg::cmrx_tx_evt_t tx_evt_o
);
  int cnt;
  always @(posedge clk_i) begin
    tx_evt_o <= '0;
    if (rst_i) begin
      cnt <= 0;
    end else if (tx_abort_i) begin
      tx_evt_o.aborted  <= 1'b1;
      tx_evt_o.pair_buf <= tx_abort_buf_i;
      cnt               <= 0;
    end else if (tx_valid_i && !hold_i) begin
      if (cnt == DELAY) begin
        tx_evt_o.done     <= 1'b1;
        tx_evt_o.pair_buf <= tx_buf_i;
        cnt               <= 0;
      end else begin
        cnt <= cnt + 1;
      end
    end else begin
      cnt <= 0;
    end
  end
endmodule
`default_nettype wire

/* File: verification/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic                   clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1, hold = 1'b1;
  logic                   cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic [7:0]             adr_i = 8'h00;
  logic [3:0]             sel_i = 4'h0;
  logic [31:0]            dat_i = 32'h0, dat_o, rd;
  logic                   ack_o, tx_valid_o, tx_abort_o;
  logic [2:0]             tx_buf_o, tx_abort_buf_o;
  cmrx_pkg::cmrx_rx_req_t rx_req_i = '0;
  cmrx_pkg::cmrx_tx_evt_t tx_evt_i;
  cmrx_pkg::cmrx_store_t  store_o;
  int                     miscompares = 0, tests_run = 0, n;

  cmrx_core i_cmrx_core (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
    .ack_o(ack_o), .rx_req_i(rx_req_i), .tx_evt_i(tx_evt_i), .store_o(store_o),
    .tx_valid_o(tx_valid_o), .tx_buf_o(tx_buf_o), .tx_abort_o(tx_abort_o),
    .tx_abort_buf_o(tx_abort_buf_o));
  cmrx_engine_model i_cmrx_engine_model (.clk_i(clk_i), .rst_i(rst_i), .hold_i(hold),
    .tx_valid_i(tx_valid_o), .tx_buf_i(tx_buf_o), .tx_abort_i(tx_abort_o),
    .tx_abort_buf_i(tx_abort_buf_o), .tx_evt_o(tx_evt_i));

  initial begin
    forever #2 clk_i = ~clk_i;
  end

  task automatic report_and_stop();
    $display("comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      miscompares++;
    end
  endtask

  // one classic cycle; waits for ack under a bound
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d, input logic [3:0] s);
    int k;
    k = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= w; adr_i <= a; dat_i <= d; sel_i <= s;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack_o !== 1'b1 && k < 20);
    rd = dat_o;
    cyc_i <= 1'b0; stb_i <= 1'b0;
    if (ack_o !== 1'b1) begin
      miscompares++;
      report_and_stop();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    wb(a, 1'b1, d, s);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    wb(a, 1'b0, 32'h0, 4'hF);
    check(rd, exp);
  endtask

  // candidate frame: standard id only, extended bits zero on both sides
  task automatic send_rx(input logic [10:0] std_identifier, input logic ext, input logic [10:0] fsid,
                         input logic [1:0] ms, input logic [3:0] fid, input logic [4:0] b,
                         input logic exp);
    @(posedge clk_i);
    rx_req_i <= {1'b1, ext, 1'b0, std_identifier, 18'h0, fid, fsid, 18'h0, 1'b0, ms, b};
    @(posedge clk_i);
    rx_req_i <= '0;
    #1 check(store_o.valid, exp);
    if (exp) check(store_o.filter_code, {1'b0, fid});
  endtask

  task automatic wait_tx(input logic v);
    int k;
    k = 0;
    while (tx_valid_o !== v && k < 200) begin
      @(posedge clk_i);
      k++;
    end
    if (tx_valid_o !== v) begin
      miscompares++;
      report_and_stop();
    end
  endtask

  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int a = 0; a <= 8'h30; a += 4) rchk(a[7:0], 32'h0);
    rchk(8'h40, 32'h0);
    wr(8'h00, 32'h0000_FFFF, 4'h3);
    rchk(8'h00, 32'h0000_FFEB);
    wr(8'h04, 32'h0000_FFFF, 4'h3);
    rchk(8'h04, 32'h0000_FFFF);
    wr(8'h18, 32'h0000_0003, 4'h1);
    rchk(8'h18, 32'h0000_0003);
    wr(8'h00, 32'h0000_FFE0, 4'h3);
    wr(8'h04, 32'h0, 4'h3);
    wr(8'h08, 32'h0, 4'h3);
    wr(8'h0C, 32'h0, 4'h3);
    wr(8'h10, 32'h0000_0008, 4'h3);
    wr(8'h14, 32'h0, 4'h3);
    send_rx(11'h123, 1'b1, 11'h123, 2'h0, 4'h1, 5'd5, 1'b1);
    send_rx(11'h124, 1'b0, 11'h123, 2'h0, 4'h2, 5'd9, 1'b0);
    send_rx(11'h7FF, 1'b0, 11'h123, 2'h1, 4'h3, 5'd5, 1'b1);
    send_rx(11'h123, 1'b1, 11'h123, 2'h2, 4'h4, 5'd9, 1'b0);
    send_rx(11'h123, 1'b0, 11'h123, 2'h2, 4'hF, 5'd20, 1'b1);
    send_rx(11'h123, 1'b0, 11'h123, 2'h3, 4'h5, 5'd9, 1'b0);
    rchk(8'h1C, 32'h0000_0020);
    rchk(8'h20, 32'h0000_0010);
    rchk(8'h24, 32'h0000_0020);
    rchk(8'h28, 32'h0);
    wr(8'h1C, 32'h0000_FFFF, 4'h3);
    rchk(8'h1C, 32'h0000_0020);
    wr(8'h1C, 32'h0, 4'h3);
    rchk(8'h1C, 32'h0);
    wr(8'h24, 32'h0000_FFFF, 4'h3);
    rchk(8'h24, 32'h0000_0020);
    wr(8'h24, 32'h0, 4'h3);
    rchk(8'h24, 32'h0);
    // filter 8 follows its own mask source, whatever the request carries
    send_rx(11'h123, 1'b0, 11'h123, 2'h1, 4'h8, 5'd9, 1'b0);
    wr(8'h18, 32'h0000_0001, 4'h1);
    send_rx(11'h7FF, 1'b0, 11'h123, 2'h3, 4'h8, 5'd9, 1'b1);
    // a candidate offered while the clock enable is low must be lost
    @(posedge clk_i);
    ce_i <= 1'b0;
    send_rx(11'h123, 1'b0, 11'h123, 2'h1, 4'h7, 5'd1, 1'b0);
    @(posedge clk_i);
    ce_i <= 1'b1;
    rchk(8'h1C, 32'h0000_0200);
    wr(8'h2C, 32'h0000_8B89, 4'h3);
    wait_tx(1'b1);
    check(tx_buf_o, 32'h1);
    hold <= 1'b0;
    wait_tx(1'b0);
    hold <= 1'b1;
    rchk(8'h2C, 32'h0000_8381);
    wr(8'h2C, 32'h0088_0000, 4'h4);
    wr(8'h2C, 32'h0080_0000, 4'h4);
    n = 0;
    do begin
      wb(8'h2C, 1'b0, 32'h0, 4'hF);
      n++;
    end while (rd[19] !== 1'b0 && n < 10);
    check(rd, 32'h00C0_8381);
    wr(8'h2C, 32'h0088_0000, 4'h4);
    rchk(8'h2C, 32'h0088_8381);
    // buffer 3 armed for automatic reply, then a matching remote frame lands in it
    wr(8'h2C, 32'h8400_0000, 4'h8);
    @(posedge clk_i);
    rx_req_i <= {3'b101, 11'h123, 18'h0, 4'h6, 11'h123, 18'h0, 1'b0, 2'h1, 5'd3};
    @(posedge clk_i);
    rx_req_i <= '0;
    rchk(8'h2C, 32'h8C88_8381);
    report_and_stop();
  end
endmodule
`default_nettype wire
